//--- verilog/scfs_top.sv
// short-circuit fault sequencer: drive gating, hiccup and latch
// assumes synchronous inputs and an AXI4-Lite master on CORE_CLK
//
// Overview of operation
// RULE_01 - a peak limit hit raises the error flag and starts the timer.
// RULE_02 - in auto-recovery, undervoltage or timer expiry stops drive.
// RULE_03 - a fault stop skips one supply start and restarts on the next.
// RULE_04 - every restart after double hiccup runs the soft-start.
// RULE_05 - in latched mode timer expiry latches off until supply reset.
// RULE_06 - early-short detection works only with the latched variant.
// RULE_07 - with early-short on, a start-up's first pulse sets the armed flag.
// RULE_08 - undervoltage while armed latches off at once.
// RULE_09 - eight regulated cycles clear armed; later undervoltage recovers.
// RULE_10 - latched mode without early-short never arms; undervoltage recovers.
// RULE_11 - early-short detection is a build option, off by default.
// RULE_12 - regulation is setpoint below limit for eight cycles in a row.
// RULE_13 - first drive pulse waits 200 us after a supply start.
// RULE_14 - the fault timer reloads whenever the error flag drops.
//
// The implementer's own choices: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/10ps
module scfs_top #(
	parameter bit EARLY_SHORT_OPT = 1'b0,
	parameter int FAULT_CYC = scfs_pkg::FAULT_CYC_DEF,
	parameter int SAFE_CYC = scfs_pkg::SAFE_CYC
) (
	input wire logic CORE_CLK,
	input wire logic NRST,
	input wire logic PEAK_LIMIT,
	input wire logic SETPOINT_LOW,
	input wire logic CYCLE_START,
	input wire scfs_pkg::scfs_supply_type SUPPLY,
	output logic DRIVE_EN,
	output logic SOFT_START,
	output logic LOW_POWER,
	output logic IRQ,
	input wire logic [7:0] AWADDR,
	input wire logic AWVALID,
	output logic AWREADY,
	input wire logic [31:0] WDATA,
	input wire logic [3:0] WSTRB,
	input wire logic WVALID,
	output logic WREADY,
	output logic [1:0] BRESP,
	output logic BVALID,
	input wire logic BREADY,
	input wire logic [7:0] ARADDR,
	input wire logic ARVALID,
	output logic ARREADY,
	output logic [31:0] RDATA,
	output logic [1:0] RRESP,
	output logic RVALID,
	input wire logic RREADY
);
	initial begin
		if (FAULT_CYC < 1 || FAULT_CYC >= (1 << scfs_pkg::CNT_W))
			$error("FAULT_CYC out of range");
		if (SAFE_CYC < 1 || SAFE_CYC >= (1 << scfs_pkg::CNT_W))
			$error("SAFE_CYC out of range");
	end

	scfs_pkg::scfs_state_type st_r, st_nxt;
	logic [scfs_pkg::CNT_W-1:0] safe_r;
	logic [3:0] reg_cnt_r;
	logic armed_r, start_seq_r, first_pulse_r;
	logic latched_mode_r, early_en_r;
	logic fault_exp, fault_stop, arm_trip;
	logic [scfs_pkg::EV_W-1:0] ev, irq_stat_r, irq_mask_r;
	logic aw_hold_r, w_hold_r;
	logic [7:0] awaddr_r;
	logic [31:0] wdata_r;
	logic do_write, rd_stat;

	// ************************************************************
	// fault timer
	// ************************************************************
	// RULE_01 RULE_14 timer runs on flag
	scfs_timer #(.W(scfs_pkg::CNT_W)) u_timer (
		.clk(CORE_CLK),
		.nrst(NRST),
		.load(scfs_pkg::CNT_W'(FAULT_CYC)),
		.run(PEAK_LIMIT && st_r == scfs_pkg::ST_RUN),
		.expired(fault_exp)
	);

	// RULE_08 armed undervoltage trips
	assign arm_trip = SUPPLY.uv_ev && armed_r;
	assign fault_stop = (SUPPLY.uv_ev || fault_exp) && st_r == scfs_pkg::ST_RUN;

	// ************************************************************
	// sequencer
	// ************************************************************
	// RULE_02 RULE_03 RULE_05 stop, hiccup, latch
	always_comb begin
		st_nxt = st_r;
		case (st_r)
			scfs_pkg::ST_OFF: begin
				if (SUPPLY.start_ev)
					st_nxt = scfs_pkg::ST_SAFE;
			end
			scfs_pkg::ST_SAFE: begin
				if (SUPPLY.uv_ev)
					st_nxt = scfs_pkg::ST_WAIT1;
				else if (safe_r == '0)
					st_nxt = scfs_pkg::ST_RUN;
			end
			scfs_pkg::ST_RUN: begin
				if (arm_trip || (fault_exp && latched_mode_r))
					st_nxt = scfs_pkg::ST_LATCH;
				else if (fault_stop)
					st_nxt = scfs_pkg::ST_WAIT1;
			end
			scfs_pkg::ST_WAIT1: begin
				// first supply start is deliberately ignored
				if (SUPPLY.start_ev)
					st_nxt = scfs_pkg::ST_WAIT2;
			end
			scfs_pkg::ST_WAIT2: begin
				if (SUPPLY.start_ev)
					st_nxt = scfs_pkg::ST_SAFE;
			end
			scfs_pkg::ST_LATCH: begin
				// hiccups ignored; only the reset level frees it
				if (SUPPLY.reset_ev)
					st_nxt = scfs_pkg::ST_OFF;
			end
			default: st_nxt = scfs_pkg::ST_OFF;
		endcase
		if (SUPPLY.reset_ev)
			st_nxt = scfs_pkg::ST_OFF;
	end

	always_ff @(posedge CORE_CLK) begin
		if (!NRST)
			st_r <= scfs_pkg::ST_OFF;
		else
			st_r <= st_nxt;
	end

	// RULE_13 safety delay count
	always_ff @(posedge CORE_CLK) begin
		if (!NRST || st_r != scfs_pkg::ST_SAFE)
			safe_r <= scfs_pkg::CNT_W'(SAFE_CYC - 1);
		else if (safe_r != '0)
			safe_r <= safe_r - 1'b1;
	end

	// RULE_04 soft-start on every restart
	always_ff @(posedge CORE_CLK) begin
		if (!NRST)
			start_seq_r <= 1'b0;
		else if (st_r == scfs_pkg::ST_SAFE)
			start_seq_r <= 1'b1;
		else if (st_r != scfs_pkg::ST_RUN)
			start_seq_r <= 1'b0;
		else if (reg_cnt_r == 4'(scfs_pkg::REG_CYCLES))
			start_seq_r <= 1'b0;
	end

	// ************************************************************
	// regulation and armed flag
	// ************************************************************
	// RULE_12 eight low setpoint cycles
	always_ff @(posedge CORE_CLK) begin
		if (!NRST || st_r != scfs_pkg::ST_RUN)
			reg_cnt_r <= 4'h0;
		else if (CYCLE_START) begin
			if (!SETPOINT_LOW)
				reg_cnt_r <= 4'h0;
			else if (reg_cnt_r != 4'(scfs_pkg::REG_CYCLES))
				reg_cnt_r <= reg_cnt_r + 4'h1;
		end
	end

	// first pulse of each start-up sequence
	always_ff @(posedge CORE_CLK) begin
		if (!NRST)
			first_pulse_r <= 1'b0;
		else if (st_r == scfs_pkg::ST_SAFE)
			first_pulse_r <= 1'b1;
		else if (CYCLE_START && DRIVE_EN)
			first_pulse_r <= 1'b0;
	end

	// RULE_06 RULE_10 RULE_11 arming gated by latched option
	// RULE_07 RULE_09 set on first pulse, clear on regulation
	always_ff @(posedge CORE_CLK) begin
		if (!NRST || st_r != scfs_pkg::ST_RUN)
			armed_r <= 1'b0;
		else if (first_pulse_r && CYCLE_START && early_en_r && latched_mode_r)
			armed_r <= 1'b1;
		else if (reg_cnt_r == 4'(scfs_pkg::REG_CYCLES))
			armed_r <= 1'b0;
	end

	// outputs from state
	always_ff @(posedge CORE_CLK) begin
		if (!NRST) begin
			DRIVE_EN <= 1'b0;
			SOFT_START <= 1'b0;
			LOW_POWER <= 1'b0;
		end else begin
			DRIVE_EN <= st_nxt == scfs_pkg::ST_RUN;
			SOFT_START <= st_nxt == scfs_pkg::ST_SAFE ||
				(st_nxt == scfs_pkg::ST_RUN && start_seq_r);
			LOW_POWER <= st_nxt == scfs_pkg::ST_WAIT1 ||
				st_nxt == scfs_pkg::ST_WAIT2 || st_nxt == scfs_pkg::ST_LATCH;
		end
	end

	// ************************************************************
	// interrupts
	// ************************************************************
	assign ev[scfs_pkg::EV_FAULT] = fault_stop;
	assign ev[scfs_pkg::EV_LATCH] = st_nxt == scfs_pkg::ST_LATCH &&
		st_r != scfs_pkg::ST_LATCH;
	assign ev[scfs_pkg::EV_UV] = SUPPLY.uv_ev;
	assign ev[scfs_pkg::EV_ARM] = first_pulse_r && CYCLE_START &&
		st_r == scfs_pkg::ST_RUN && early_en_r && latched_mode_r;

	// set wins over the clear-on-read
	always_ff @(posedge CORE_CLK) begin
		if (!NRST)
			irq_stat_r <= '0;
		else if (rd_stat)
			irq_stat_r <= ev;
		else
			irq_stat_r <= irq_stat_r | ev;
	end
	assign IRQ = |(irq_stat_r & irq_mask_r);

	// ************************************************************
	// axi4-lite slave
	// ************************************************************
	assign AWREADY = !aw_hold_r && !BVALID;
	assign WREADY = !w_hold_r && !BVALID;
	assign ARREADY = !RVALID;
	assign do_write = aw_hold_r && w_hold_r;
	assign rd_stat = ARVALID && ARREADY && ARADDR == scfs_pkg::OFS_IRQ;

	// capture address and data in either order
	always_ff @(posedge CORE_CLK) begin
		if (!NRST) begin
			aw_hold_r <= 1'b0;
			w_hold_r <= 1'b0;
			awaddr_r <= 8'h00;
			wdata_r <= 32'h0000_0000;
		end else begin
			if (AWVALID && AWREADY) begin
				aw_hold_r <= 1'b1;
				awaddr_r <= AWADDR;
			end else if (do_write)
				aw_hold_r <= 1'b0;
			if (WVALID && WREADY) begin
				w_hold_r <= 1'b1;
				wdata_r <= WSTRB[0] ? WDATA : 32'h0000_0000;
			end else if (do_write)
				w_hold_r <= 1'b0;
		end
	end

	// writable config; only the early-short bit is gated by the build option
	always_ff @(posedge CORE_CLK) begin
		if (!NRST) begin
			latched_mode_r <= 1'b0;
			early_en_r <= EARLY_SHORT_OPT;
			irq_mask_r <= '0;
			BVALID <= 1'b0;
			BRESP <= scfs_pkg::RESP_OK;
		end else if (do_write) begin
			BVALID <= 1'b1;
			BRESP <= scfs_pkg::RESP_OK;
			if (awaddr_r == scfs_pkg::OFS_CTRL) begin
				latched_mode_r <= wdata_r[scfs_pkg::CTRL_LATCHED];
				early_en_r <= EARLY_SHORT_OPT &&
					wdata_r[scfs_pkg::CTRL_EARLY];
			end else if (awaddr_r == scfs_pkg::OFS_MASK)
				irq_mask_r <= wdata_r[scfs_pkg::EV_W-1:0];
			else
				BRESP <= scfs_pkg::RESP_ERR;
		end else if (BVALID && BREADY)
			BVALID <= 1'b0;
	end

	// read data
	always_ff @(posedge CORE_CLK) begin
		if (!NRST) begin
			RVALID <= 1'b0;
			RDATA <= 32'h0000_0000;
			RRESP <= scfs_pkg::RESP_OK;
		end else if (ARVALID && ARREADY) begin
			RVALID <= 1'b1;
			RRESP <= scfs_pkg::RESP_OK;
			case (ARADDR)
				scfs_pkg::OFS_CTRL:
					RDATA <= {30'h0, early_en_r, latched_mode_r};
				scfs_pkg::OFS_STAT:
					RDATA <= {24'h0, armed_r, DRIVE_EN, 1'b0, st_r, 2'h0};
				scfs_pkg::OFS_IRQ: RDATA <= {28'h0, irq_stat_r};
				scfs_pkg::OFS_MASK: RDATA <= {28'h0, irq_mask_r};
				default: begin
					RDATA <= 32'h0000_0000;
					RRESP <= scfs_pkg::RESP_ERR;
				end
			endcase
		end else if (RVALID && RREADY)
			RVALID <= 1'b0;
	end
endmodule

//--- verilog/scfs_pkg.sv
// package for the short-circuit fault sequencer
// assumes a single 250 MHz core clock domain
package scfs_pkg;
	// ************************************************************
	// timing
	// ************************************************************
	localparam int CLK_MHZ = 250;
	localparam int SAFE_US = 200;
	localparam int SAFE_CYC = SAFE_US * CLK_MHZ;
	localparam int FAULT_CYC_DEF = 32'h0013_12D0;
	localparam int REG_CYCLES = 8;
	localparam int CNT_W = 24;
	// ************************************************************
	// register map (own choice; no offsets printed)
	// ************************************************************
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_STAT = 8'h04;
	localparam logic [7:0] OFS_IRQ = 8'h08;
	localparam logic [7:0] OFS_MASK = 8'h0C;
	localparam int CTRL_LATCHED = 0;
	localparam int CTRL_EARLY = 1;
	localparam int EV_W = 4;
	localparam int EV_FAULT = 0;
	localparam int EV_LATCH = 1;
	localparam int EV_UV = 2;
	localparam int EV_ARM = 3;
	localparam logic [1:0] RESP_OK = 2'h0;
	localparam logic [1:0] RESP_ERR = 2'h2;

	typedef enum logic [2:0] {
		ST_OFF = 3'h0,
		ST_SAFE = 3'h1,
		ST_RUN = 3'h2,
		ST_WAIT1 = 3'h3,
		ST_WAIT2 = 3'h4,
		ST_LATCH = 3'h5
	} scfs_state_type;

	// supply comparator events, one cycle each
	typedef struct packed {
		logic start_ev;
		logic min_ev;
		logic reset_ev;
		logic uv_ev;
	} scfs_supply_type;
endpackage

//--- verilog/scfs_timer.sv
// fault timer: counts down while the error flag is up
// assumes error flag synchronous to CORE_CLK
`timescale 1ns/10ps
module scfs_timer #(
	parameter int W = 24
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic [W-1:0] load,
	input wire logic run,
	output logic expired
);
	logic [W-1:0] cnt_r;

	// reload whenever the flag drops so only an unbroken fault counts
	always_ff @(posedge clk) begin
		if (!nrst || !run) begin
			cnt_r <= load;
		end else if (cnt_r != '0) begin
			cnt_r <= cnt_r - 1'b1;
		end
	end
	assign expired = run && (cnt_r == '0);
endmodule

//--- testbench/scfs_monitor.sv
// checker on the fault sequencer ports
// assumes it is bound into scfs_top
`timescale 1ns/10ps
module scfs_monitor #(
	parameter int FAULT_CYC = 20,
	parameter int SAFE_CYC = 10
) (
	input wire logic CORE_CLK,
	input wire logic NRST,
	input wire logic PEAK_LIMIT,
	input wire scfs_pkg::scfs_supply_type SUPPLY,
	input wire logic DRIVE_EN,
	input wire logic SOFT_START,
	input wire logic LOW_POWER,
	input wire logic ARVALID,
	input wire logic ARREADY,
	input wire logic RVALID
);
	// ********
	// counters
	// ********
	// ********
	int flt_r;
	int safe_r;
	// overload run while driving; a stuck timer grows it past the limit
	always_ff @(posedge CORE_CLK) begin
		if (!NRST || !(PEAK_LIMIT && DRIVE_EN)) begin
			flt_r <= 0;
		end else begin
			flt_r <= flt_r + 1;
		end
	end
	// length of the safety wait before drive
	always_ff @(posedge CORE_CLK) begin
		if (!NRST || !SOFT_START || DRIVE_EN) begin
			safe_r <= 0;
		end else begin
			safe_r <= safe_r + 1;
		end
	end
	default clocking @(posedge CORE_CLK);
	endclocking
	default disable iff (!NRST);
	a_uv_stop: assert property (SUPPLY.uv_ev && DRIVE_EN |=> !DRIVE_EN)
		else $error("drive kept after undervoltage");
	a_reset_off: assert property (SUPPLY.reset_ev |=> !DRIVE_EN && !LOW_POWER)
		else $error("reset level did not clear");
	a_fault_limit: assert property (flt_r <= FAULT_CYC + 1)
		else $error("fault time overrun");
	a_hiccup_quiet: assert property (LOW_POWER |-> !DRIVE_EN)
		else $error("drive in low power");
	a_soft_restart: assert property ($rose(DRIVE_EN) |-> SOFT_START)
		else $error("restart without soft start");
	a_safe_len: assert property ($rose(DRIVE_EN) |-> safe_r >= SAFE_CYC)
		else $error("safety wait too short");
	a_start_idle: assert property (SUPPLY.start_ev && !DRIVE_EN |=> !DRIVE_EN [*8])
		else $error("drive right after start");
	a_rd_answer: assert property (ARVALID && ARREADY |=> RVALID)
		else $error("read answer late");
endmodule
bind scfs_top scfs_monitor #(.FAULT_CYC(FAULT_CYC), .SAFE_CYC(SAFE_CYC)) u_mon (.*);

//--- testbench/scfs_supply_model.sv
// supply capacitor, aux winding and switch model
// assumes drive level from the sequencer; mode[0] overload, mode[1] short
`timescale 1ns/10ps
module scfs_supply_model #(
	parameter int TOP = 40,
	parameter int MIN = 20,
	parameter int RST = 5
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic drive,
	input wire logic [1:0] mode,
	input wire logic unplug,
	output scfs_pkg::scfs_supply_type sup = '0,
	output logic peak = 1'b0,
	output logic set_low = 1'b0,
	output logic cyc = 1'b0
);
	// ********
	// supply level
	// ********
	int v = 0;
	logic up = 1'b1;
	logic [1:0] ph = 2'h0;
	// aux holds the level while driving unless the output is shorted
	always @(posedge clk) begin
		sup <= '0;
		ph <= ph + 2'h1;
		cyc <= ph == 2'h3;
		peak <= mode[0] && drive;
		set_low <= !mode[0];
		if (!nrst) begin
			v <= 0;
			up <= 1'b1;
		end else if (unplug) begin
			up <= 1'b1;
			v <= (v > 0) ? v - 1 : 0;
			sup.reset_ev <= v == RST + 1;
		end else if (drive && !mode[1]) begin
			v <= v;
		end else if (up) begin
			v <= v + 1;
			sup.start_ev <= v == TOP - 1;
			up <= v != TOP - 1;
		end else begin
			v <= v - 1;
			sup.uv_ev <= v == MIN + 1;
			sup.min_ev <= v == MIN + 1;
			up <= v == MIN + 1;
		end
	end
endmodule

//--- testbench/short_circuit_fault_sequencer_bench.sv
// self-checking bench for the fault sequencer
// assumes the supply model on the far side and the bound checker
`timescale 1ns/10ps
module short_circuit_fault_sequencer_bench;
	// ********
	// harness
	// ********
	logic CORE_CLK = 0, NRST = 0, PEAK_LIMIT, SETPOINT_LOW, CYCLE_START;
	logic DRIVE_EN, SOFT_START, LOW_POWER, IRQ, unplug = 0;
	scfs_pkg::scfs_supply_type SUPPLY;
	logic [7:0] AWADDR = 0, ARADDR = 0;
	logic [31:0] WDATA = 0, RDATA, d, r;
	logic [3:0] WSTRB = 4'hF;
	logic AWVALID = 0, WVALID = 0, BREADY = 0, ARVALID = 0, RREADY = 0;
	logic AWREADY, WREADY, BVALID, ARREADY, RVALID;
	logic [1:0] BRESP, RRESP, rs, mode = 0;
	int num_errors = 0, checked = 0, tmo, seed = 32'h4A8A, nst = 0, s0;
	always #2 CORE_CLK = ~CORE_CLK;
	always @(posedge CORE_CLK) if (SUPPLY.start_ev) nst <= nst + 1;
	scfs_top #(.EARLY_SHORT_OPT(1'b1), .FAULT_CYC(20), .SAFE_CYC(10)) u_dut (.*);
	scfs_supply_model u_far (.clk(CORE_CLK), .nrst(NRST), .drive(DRIVE_EN),
		.mode(mode), .unplug(unplug), .sup(SUPPLY), .peak(PEAK_LIMIT),
		.set_low(SETPOINT_LOW), .cyc(CYCLE_START));
	task results;
		$display("checked %0d errors %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] e);
		checked++;
		if (g !== e) begin
			num_errors++;
			$display("unexpected %0t got %h want %h", $time, g, e);
		end
	endtask
	// bounded wait step; running out ends the run
	task tick;
		@(negedge CORE_CLK);
		tmo++;
		if (tmo > 3000) begin
			num_errors++;
			$display("unexpected %0t timeout", $time);
			results;
		end
	endtask
	task wr(input logic [7:0] a, input logic [31:0] v);
		logic aw, w;
		aw = 0;
		w = 0;
		tmo = 0;
		@(posedge CORE_CLK);
		AWADDR <= a;
		WDATA <= v;
		AWVALID <= 1;
		WVALID <= 1;
		BREADY <= 1;
		while (!(aw && w)) begin
			tick;
			aw = aw | (AWVALID & AWREADY);
			w = w | (WVALID & WREADY);
			@(posedge CORE_CLK);
			if (aw) AWVALID <= 0;
			if (w) WVALID <= 0;
		end
		do tick; while (BVALID !== 1'b1);
		rs = BRESP;
		@(posedge CORE_CLK);
		BREADY <= 0;
	endtask
	task rd(input logic [7:0] a);
		tmo = 0;
		@(posedge CORE_CLK);
		ARADDR <= a;
		ARVALID <= 1;
		RREADY <= 1;
		do tick; while (ARREADY !== 1'b1);
		@(posedge CORE_CLK);
		ARVALID <= 0;
		do tick; while (RVALID !== 1'b1);
		r = RDATA;
		rs = RRESP;
		@(posedge CORE_CLK);
		RREADY <= 0;
	endtask
	task wdrv(input logic l);
		tmo = 0;
		while (DRIVE_EN !== l) tick;
	endtask
	task set_mode(input logic [1:0] m);
		@(posedge CORE_CLK);
		mode <= m;
	endtask
	// unplug to below the reset level, then start up again
	task replug;
		set_mode(2'h0);
		unplug <= 1;
		wdrv(0);
		repeat (40) @(posedge CORE_CLK);
		tick;
		chk(LOW_POWER, 0);
		@(posedge CORE_CLK);
		unplug <= 0;
		wdrv(1);
	endtask
	initial begin
		repeat (5) @(posedge CORE_CLK);
		NRST <= 1;
		d = $random(seed);
		wr(scfs_pkg::OFS_MASK, {28'h0, d[3:0]});
		wr(8'h10, 32'h1);
		chk(rs, scfs_pkg::RESP_ERR);
		rd(scfs_pkg::OFS_CTRL);
		chk(r, 32'h2);
		wr(scfs_pkg::OFS_CTRL, 32'h2);
		wdrv(1);
		repeat ({$random(seed)} % 8) @(posedge CORE_CLK);
		set_mode(2'h1);
		wdrv(0);
		s0 = nst;
		tick;
		chk(LOW_POWER, 1);
		chk(IRQ, d[0]);
		rd(scfs_pkg::OFS_IRQ);
		chk(r & 32'h9, 32'h1);
		$display("auto recovery stop done");
		set_mode(2'h0);
		wdrv(1);
		chk(nst - s0, 2);
		chk(SOFT_START, 1);
		wr(scfs_pkg::OFS_CTRL, 32'h1);
		replug;
		rd(scfs_pkg::OFS_STAT);
		chk(r[7], 0);
		set_mode(2'h3);
		wdrv(0);
		rd(scfs_pkg::OFS_STAT);
		chk(r[4:2], 3);
		set_mode(2'h1);
		wdrv(1);
		wdrv(0);
		rd(scfs_pkg::OFS_STAT);
		chk(r[4:2], 5);
		$display("latched variant done");
		wr(scfs_pkg::OFS_CTRL, 32'h3);
		replug;
		repeat (6) @(posedge CORE_CLK);
		rd(scfs_pkg::OFS_STAT);
		chk(r[7], 1);
		set_mode(2'h3);
		wdrv(0);
		rd(scfs_pkg::OFS_STAT);
		chk(r[4:2], 5);
		replug;
		repeat (60) @(posedge CORE_CLK);
		rd(scfs_pkg::OFS_STAT);
		chk(r[7], 0);
		chk(SOFT_START, 0);
		set_mode(2'h3);
		wdrv(0);
		rd(scfs_pkg::OFS_STAT);
		chk(r[4:2], 3);
		$display("early short done");
		results;
	end
endmodule
